// ==== src/pfs_int_gate.sv ====
/*
  pfs_int_gate: registered interrupt output gate.
  assumes: pending and disable are synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module pfs_int_gate (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic pending,
  input  wire logic disable_int,
  output var  logic int_assert_q
);

  // disable only masks the pin, pending is untouched upstream
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      int_assert_q <= 1'b0;
    end else begin
      int_assert_q <= pending & ~disable_int; // see [R13]
    end
  end

endmodule // pfs_int_gate

`default_nettype wire

// ==== src/pfs_pkg.sv ====
/*
  pfs_pkg: constants and carrier types for the function status register.
  assumes: a configuration access port that presents a 16-bit half-word
  at the status offset with per-byte write strobes.
*/
package pfs_pkg;

  localparam logic [7:0]  PFS_STATUS_OFFSET = 8'h06;
  localparam logic [15:0] PFS_STATUS_RESET  = 16'h0210;

  localparam int PFS_BIT_PARITY_FAULT    = 15;
  localparam int PFS_BIT_SYSTEM_FAULT    = 14;
  localparam int PFS_BIT_MASTER_TERM     = 13;
  localparam int PFS_BIT_RX_TARGET_TERM  = 12;
  localparam int PFS_BIT_TX_TARGET_TERM  = 11;
  localparam int PFS_BIT_DEVSEL_HI       = 10;
  localparam int PFS_BIT_DEVSEL_LO       = 9;
  localparam int PFS_BIT_MASTER_DPAR     = 8;
  localparam int PFS_BIT_BACK_TO_BACK    = 7;
  localparam int PFS_BIT_USER_FEATURE    = 6;
  localparam int PFS_BIT_HIGH_SPEED      = 5;
  localparam int PFS_BIT_CAP_LIST        = 4;
  localparam int PFS_BIT_INT_PENDING     = 3;

  localparam logic [1:0] PFS_DEVSEL_MEDIUM          = 2'h1;
  localparam logic       PFS_BACK_TO_BACK_CAPABLE   = 1'h0;
  localparam logic       PFS_USER_FEATURE_SUPPORT   = 1'h0;
  localparam logic       PFS_HIGH_SPEED_CAPABLE     = 1'h0;
  localparam logic       PFS_CAPABILITY_LIST_PRESENT = 1'h1;

  localparam logic [15:0] PFS_CLEARABLE_MASK = 16'hF900;

  // one-cycle bus event strobes from the bus interface logic
  typedef struct packed {
    logic addr_parity_fault;
    logic data_parity_fault;
    logic system_fault_driven;
    logic master_termination;
    logic target_termination_rx;
    logic target_termination_tx;
    logic parity_error_seen;
    logic acting_as_master;
  } pfs_events_t;

  // command register bits that steer this block
  typedef struct packed {
    logic interrupt_disable;
    logic system_error_enable;
    logic parity_response_enable;
  } pfs_control_t;

  // configuration write to the status half-word
  typedef struct packed {
    logic        strobe;
    logic [1:0]  byte_en;
    logic [15:0] data;
  } pfs_write_t;

endpackage

// ==== src/pfs_status_reg.sv ====
/*
  pfs_status_reg: 16-bit bus error and capability status register.
  assumes: event strobes and command bits come from neighbouring logic on
  mclk; configuration accesses arrive through the documented port.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R01] write one clears, zero keeps, reads pure
// [R02] bit 15 sets on address or data parity
// [R03] bit 14 sets on enabled system error
// [R04] bit 13 sets on received master abort
// [R05] bit 12 sets on received target abort
// [R06] bit 11 sets on signalled target abort
// [R07] devsel timing field reads 01b
// [R08] bit 8 needs perr, mastership, response enable
// [R09] bit 7 reads zero
// [R10] bit 6 reads zero
// [R11] bit 5 reads zero
// [R12] bit 4 reads one
// [R13] interrupt pin asserts when pending and enabled
// [R14] interrupt disable masks pin only
// [R15] pending only for enabled interrupt conditions
// [R16] bits 2 to 0 read zero
// [R17] system error driver needs enable bit
// [R18] set beats same-cycle clear
module pfs_status_reg (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire pfs_pkg::pfs_events_t  events,
  input  wire pfs_pkg::pfs_control_t control,
  input  wire logic                  irq_condition,
  input  wire logic                  irq_signal_enable,
  input  wire logic                  irq_condition_gone,
  input  wire pfs_pkg::pfs_write_t   cfg_write,
  output var  logic [15:0]           status_q,
  output var  logic                  system_fault_drive_q,
  output var  logic                  int_assert_q
);

  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [15:0] sticky_q;
  logic [15:0] sticky_d;
  logic        pending_q;
  logic        serr_fire;

  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // driver only when enabled; fires on address parity
  assign serr_fire = control.system_error_enable &
                     events.addr_parity_fault; // see [R17]

  always_comb begin
    set_vec = 16'h0000;
    set_vec[pfs_pkg::PFS_BIT_PARITY_FAULT] =
      events.addr_parity_fault | events.data_parity_fault; // see [R02]
    set_vec[pfs_pkg::PFS_BIT_SYSTEM_FAULT] =
      control.system_error_enable & events.system_fault_driven; // see [R03]
    set_vec[pfs_pkg::PFS_BIT_MASTER_TERM] =
      events.master_termination; // see [R04]
    set_vec[pfs_pkg::PFS_BIT_RX_TARGET_TERM] =
      events.target_termination_rx; // see [R05]
    set_vec[pfs_pkg::PFS_BIT_TX_TARGET_TERM] =
      events.target_termination_tx; // see [R06]
    set_vec[pfs_pkg::PFS_BIT_MASTER_DPAR] =
      events.parity_error_seen & events.acting_as_master &
      control.parity_response_enable; // see [R08]
  end

  // only one-bits in enabled lanes of clearable positions clear
  assign clr_vec = cfg_write.strobe ?
                   (cfg_write.data & lane_mask(cfg_write.byte_en) &
                    pfs_pkg::PFS_CLEARABLE_MASK) : 16'h0000; // see [R01]

  assign sticky_d = (sticky_q & ~clr_vec) | set_vec; // see [R18]

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sticky_q <= 16'h0000;
    end else begin
      sticky_q <= sticky_d & pfs_pkg::PFS_CLEARABLE_MASK;
    end
  end

  // pending is an update bit: follows the source, not write-clearable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pending_q <= 1'b0;
    end else if (irq_condition & irq_signal_enable) begin
      pending_q <= 1'b1; // see [R15]
    end else if (irq_condition_gone) begin
      pending_q <= 1'b0;
    end
  end

  // hardwired fields are merged here so writes can never reach them
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_q <= pfs_pkg::PFS_STATUS_RESET;
    end else begin
      status_q <= sticky_d & pfs_pkg::PFS_CLEARABLE_MASK;
      status_q[pfs_pkg::PFS_BIT_DEVSEL_HI:pfs_pkg::PFS_BIT_DEVSEL_LO] <=
        pfs_pkg::PFS_DEVSEL_MEDIUM; // see [R07]
      status_q[pfs_pkg::PFS_BIT_BACK_TO_BACK] <=
        pfs_pkg::PFS_BACK_TO_BACK_CAPABLE; // see [R09]
      status_q[pfs_pkg::PFS_BIT_USER_FEATURE] <=
        pfs_pkg::PFS_USER_FEATURE_SUPPORT; // see [R10]
      status_q[pfs_pkg::PFS_BIT_HIGH_SPEED] <=
        pfs_pkg::PFS_HIGH_SPEED_CAPABLE; // see [R11]
      status_q[pfs_pkg::PFS_BIT_CAP_LIST] <=
        pfs_pkg::PFS_CAPABILITY_LIST_PRESENT; // see [R12]
      status_q[pfs_pkg::PFS_BIT_INT_PENDING] <=
        (irq_condition & irq_signal_enable) |
        (pending_q & ~irq_condition_gone);
      status_q[2:0] <= 3'h0; // see [R16]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      system_fault_drive_q <= 1'b0;
    end else begin
      system_fault_drive_q <= serr_fire; // see [R17]
    end
  end

  // disable feeds the gate only, never pending_q
  pfs_int_gate u_int_gate (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .pending      (pending_q),
    .disable_int  (control.interrupt_disable), // see [R14]
    .int_assert_q (int_assert_q)
  );

endmodule // pfs_status_reg

`default_nettype wire

// ==== testbench/pfs_bus_agent.sv ====
/* pfs_bus_agent: far-side bus agents, seen as event pulses.
   assumes: pulse is driven just after the mclk edge. */
`timescale 1ns/1ps
`default_nettype none
module pfs_bus_agent (
  input  wire logic                 mclk,
  input  wire pfs_pkg::pfs_events_t pulse,
  output var  pfs_pkg::pfs_events_t events
);
  initial events = '0;
  // registered so each pulse value is held for exactly one bus cycle
  always @(posedge mclk) events <= #1 pulse;
endmodule // pfs_bus_agent
`default_nettype wire

// ==== testbench/pfs_status_reg_bench.sv ====
/* pfs_status_reg_bench: random self-checking bench for the status reg.
   assumes: pfs_pkg, pfs_status_reg and pfs_bus_agent are compiled. */
`timescale 1ns/1ps
`default_nettype none
module pfs_status_reg_bench;
  logic                  mclk = 0, sys_rst = 1, ic = 0, ie = 0, ig = 0;
  pfs_pkg::pfs_events_t  pulse = '0, ev;
  pfs_pkg::pfs_control_t ctl = '0;
  pfs_pkg::pfs_write_t   wr = '0;
  logic [15:0]           st, x = 16'h0210;
  logic                  serr, intq;
  logic [17:0]           q[$];
  logic [17:0]           e;
  int                    num_errors = 0, checked = 0, seed = 86;
  always #25 mclk = ~mclk;
  pfs_bus_agent u_pfs_bus_agent (.mclk(mclk), .pulse(pulse), .events(ev));
  pfs_status_reg u_pfs_status_reg (.mclk(mclk), .sys_rst(sys_rst),
    .events(ev), .control(ctl), .irq_condition(ic),
    .irq_signal_enable(ie), .irq_condition_gone(ig), .cfg_write(wr),
    .status_q(st), .system_fault_drive_q(serr), .int_assert_q(intq));
  task check(input logic [17:0] s, input logic [17:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t out %h exp %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task go;
    logic [15:0] c;
    logic        i, s;
    @(posedge mclk);
    c = {wr.byte_en[1] ? wr.data[15:8] : 8'h0,
         wr.byte_en[0] ? wr.data[7:0] : 8'h0} & {16{wr.strobe}} & 16'hF900;
    i = x[3] & ~ctl.interrupt_disable;
    s = ev.addr_parity_fault & ctl.system_error_enable;
    x = (x & ~c) | 16'h0210 | {ev.addr_parity_fault | ev.data_parity_fault,
      ev.system_fault_driven & ctl.system_error_enable,
      ev.master_termination, ev.target_termination_rx,
      ev.target_termination_tx, 2'h0, ev.parity_error_seen
      & ev.acting_as_master & ctl.parity_response_enable, 8'h0};
    x[3] = (ic & ie) | (x[3] & ~ig);
    if (sys_rst) begin
      {i, s, x} = {2'h0, 16'h0210};
    end
    q.push_back({i, s, x});
    #1;
  endtask
  // the model runs in go; this process only compares what it noted
  always @(posedge mclk) begin
    #2;
    if (q.size() > 0) begin
      e = q.pop_front();
      check(st, e[15:0]);
      check(intq, e[17]);
      check(serr, e[16]);
    end
  end
  initial begin
    repeat (10) go;
    sys_rst = 0;
    for (int n = 0; n < 800; n++) begin
      go;
      pulse = 8'($random(seed) & $random(seed));
      ctl = 3'($random(seed));
      wr = 19'($random(seed));
      {ic, ie, ig} = 3'($random(seed));
      sys_rst = (n == 400);
    end
    repeat (2) go;
    // let the compare process take the last note first
    #2;
    finish_test;
  end
endmodule // pfs_status_reg_bench
bind pfs_status_reg pfs_status_reg_checker u_pfs_status_reg_checker (
  .mclk(mclk), .sys_rst(sys_rst), .events(events), .control(control),
  .irq_condition(irq_condition), .irq_signal_enable(irq_signal_enable),
  .cfg_write(cfg_write), .status_q(status_q),
  .system_fault_drive_q(system_fault_drive_q), .int_assert_q(int_assert_q));
`default_nettype wire

// ==== testbench/pfs_status_reg_checker.sv ====
/* pfs_status_reg_checker: port assertions for the status register.
   assumes: bound to pfs_status_reg; one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module pfs_status_reg_checker (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire pfs_pkg::pfs_events_t  events,
  input wire pfs_pkg::pfs_control_t control,
  input wire logic                  irq_condition,
  input wire logic                  irq_signal_enable,
  input wire pfs_pkg::pfs_write_t   cfg_write,
  input wire logic [15:0]           status_q,
  input wire logic                  system_fault_drive_q,
  input wire logic                  int_assert_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_pend; irq_condition && irq_signal_enable; endsequence
  a_fixed_bits: assert property (
    (status_q & 16'h06F7) == 16'h0210)
    else $error("fixed bits wrong");
  a_parity_set: assert property (
    events.addr_parity_fault || events.data_parity_fault |=> status_q[15])
    else $error("bit 15 not set");
  a_set_wins: assert property (
    events.master_termination |=> status_q[13])
    else $error("bit 13 not set");
  a_one_clears: assert property (
    cfg_write.strobe && cfg_write.byte_en[1] && cfg_write.data[13]
    && !events.master_termination |=> !status_q[13])
    else $error("bit 13 not cleared");
  // sticky bits may only fall through a write
  a_sticky_keep: assert property (
    !cfg_write.strobe
    |=> ($past(status_q) & ~status_q & 16'hF900) == 16'h0000)
    else $error("sticky bit lost");
  a_dpar_cause: assert property (
    $rose(status_q[8]) |-> $past(events.parity_error_seen)
    && $past(events.acting_as_master)
    && $past(control.parity_response_enable))
    else $error("bit 8 without cause");
  a_irq_path: assert property (
    s_pend ##1 !control.interrupt_disable |=> int_assert_q)
    else $error("interrupt not asserted");
  a_serr_off: assert property (
    !control.system_error_enable |=> !system_fault_drive_q)
    else $error("system fault while disabled");
  a_serr_fire: assert property (
    control.system_error_enable && events.addr_parity_fault
    |=> system_fault_drive_q)
    else $error("system fault not driven");
endmodule // pfs_status_reg_checker
`default_nettype wire
